// ==== design/usr_shift_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Both selects high loads all four inputs.
// - Load takes effect only on step edge.
// - Serial inputs ignored during parallel load.
// - Low select only: shift first toward last.
// - Right shift: first stage takes right input.
// - High select only: shift last toward first.
// - Left shift: last stage takes left input.
// - Both selects low: stages hold.
// - Clear overrides everything, zeroing all stages.
// - Every stage visible on parallel outputs.
module usr_shift_top import usr_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear_n,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [USR_WIDTH-1:0] parallel_output,
   output logic first_stage_output,
   output logic last_stage_output
);

   // Write channel state: address and data may arrive in either order.
   logic awready_q;
   logic wready_q;
   logic aw_have_q;
   logic w_have_q;
   logic [4:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;

   // Read channel state.
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // Software-visible registers.
   usr_ctrl_t ctrl_q;
   logic [USR_WIDTH-1:0] data_q;
   logic [15:0] div_q;
   logic step_q;

   // Stage contents, divider tick and the combined step enable.
   logic [USR_WIDTH-1:0] stage_q;
   logic tick_q;
   logic step;
   logic wr_fire;
   logic wr_map_ok;
   logic rd_map_ok;
   logic [31:0] rd_word;

   // A write is carried out once both halves are held and no response is pending.
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

   // The stage clock is the software step or a divider tick while running.
   assign step = step_q || tick_q;

   // Outputs come straight from flip-flops.
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign parallel_output = stage_q;
   assign first_stage_output = stage_q[0];
   assign last_stage_output = stage_q[USR_WIDTH-1];

   // Address decode of the held write address.
   always_comb begin
      unique case (awaddr_q)
         USR_ADDR_CTRL, USR_ADDR_DATA, USR_ADDR_STEP, USR_ADDR_DIV: wr_map_ok = 1'b1;
         default: wr_map_ok = 1'b0;
      endcase
   end

   // Read multiplexer; unmapped addresses read zero with an error response.
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_map_ok = 1'b1;
      unique case (s_axi_araddr)
         USR_ADDR_CTRL: rd_word[USR_CTRL_BITS-1:0] = ctrl_q;
         USR_ADDR_DATA: rd_word[USR_WIDTH-1:0] = data_q;
         USR_ADDR_STEP: rd_word = 32'h0000_0000;
         USR_ADDR_STATUS: rd_word[USR_WIDTH-1:0] = stage_q;
         USR_ADDR_DIV: rd_word[15:0] = div_q;
         default: rd_map_ok = 1'b0;
      endcase
   end

   // Write address capture; ready drops while an address is held.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b0;
         awaddr_q <= 5'h00;
      end else if (s_axi_awvalid && awready_q) begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end else if (!aw_have_q && !bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   // Write data capture, mirroring the address side.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_q <= 1'b0;
         w_have_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && wready_q) begin
         wready_q <= 1'b0;
         w_have_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end else if (!w_have_q && !bvalid_q) begin
         wready_q <= 1'b1;
      end
   end

   // Write response is raised at the same edge as the register update.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= USR_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_map_ok ? USR_RESP_OKAY : USR_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Control, data and divider registers; byte lanes are honoured.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= usr_ctrl_t'(USR_CTRL_RST);
         data_q <= USR_DATA_RST;
         div_q <= USR_DIV_RST;
      end else if (wr_fire) begin
         if (awaddr_q == USR_ADDR_CTRL && wstrb_q[0]) begin
            ctrl_q <= usr_ctrl_t'(wdata_q[USR_CTRL_BITS-1:0]);
         end
         if (awaddr_q == USR_ADDR_DATA && wstrb_q[0]) begin
            data_q <= wdata_q[USR_WIDTH-1:0];
         end
         if (awaddr_q == USR_ADDR_DIV && wstrb_q[0]) begin
            div_q[7:0] <= wdata_q[7:0];
         end
         if (awaddr_q == USR_ADDR_DIV && wstrb_q[1]) begin
            div_q[15:8] <= wdata_q[15:8];
         end
      end
   end

   // Any write to the step address gives exactly one step, the block's clock edge.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_q <= 1'b0;
      end else begin
         step_q <= wr_fire && (awaddr_q == USR_ADDR_STEP);
      end
   end

   // Read channel: data is registered at the same edge that takes the address.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= USR_RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_map_ok ? USR_RESP_OKAY : USR_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   // Divider for free-running stepping; a software step may coincide with a tick.
   usr_rate_div u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(ctrl_q.run),
      .div_count(div_q),
      .tick_q(tick_q)
   );

   // The stages themselves.
   usr_stage_core u_core (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear_n(clear_n),
      .step(step),
      .ctrl(ctrl_q),
      .par_in(data_q),
      .stage_q(stage_q)
   );

   // Checks on the stages per step and selected mode, on clear, on the end outputs and on the step pulse.
   property p_load;
      @(posedge aclk) disable iff (!aresetn || !clear_n)
      step && ctrl_q.mode == USR_LOAD |=> stage_q == $past(data_q);
   endproperty
   a_load: assert property (p_load) else $error("parallel load lost");

   // A load is seen only after a step, never before it.
   property p_load_edge;
      @(posedge aclk) disable iff (!aresetn || !clear_n)
      !step |=> stage_q == $past(stage_q);
   endproperty
   a_load_edge: assert property (p_load_edge) else $error("stage moved without step");

   // During load the serial inputs have no say in any stage.
   property p_no_serial;
      @(posedge aclk) disable iff (!aresetn || !clear_n)
      step && ctrl_q.mode == USR_LOAD && (ctrl_q.serial_right_in || ctrl_q.serial_left_in)
         |=> stage_q == $past(data_q);
   endproperty
   a_no_serial: assert property (p_no_serial) else $error("serial data entered on load");

   // Right shift moves every stage one place toward the last.
   property p_shr;
      @(posedge aclk) disable iff (!aresetn || !clear_n)
      step && ctrl_q.mode == USR_SHR
         |=> stage_q[USR_WIDTH-1:1] == $past(stage_q[USR_WIDTH-2:0]);
   endproperty
   a_shr: assert property (p_shr) else $error("right shift wrong");

   // Right shift fills the first stage from the right serial input.
   property p_shr_in;
      @(posedge aclk) disable iff (!aresetn || !clear_n)
      step && ctrl_q.mode == USR_SHR |=> stage_q[0] == $past(ctrl_q.serial_right_in);
   endproperty
   a_shr_in: assert property (p_shr_in) else $error("right serial input lost");

   // Left shift moves every stage one place toward the first.
   property p_shl;
      @(posedge aclk) disable iff (!aresetn || !clear_n)
      step && ctrl_q.mode == USR_SHL
         |=> stage_q[USR_WIDTH-2:0] == $past(stage_q[USR_WIDTH-1:1]);
   endproperty
   a_shl: assert property (p_shl) else $error("left shift wrong");

   // Left shift fills the last stage from the left serial input.
   property p_shl_in;
      @(posedge aclk) disable iff (!aresetn || !clear_n)
      step && ctrl_q.mode == USR_SHL
         |=> stage_q[USR_WIDTH-1] == $past(ctrl_q.serial_left_in);
   endproperty
   a_shl_in: assert property (p_shl_in) else $error("left serial input lost");

   // Hold mode keeps the stages through a step.
   property p_hold;
      @(posedge aclk) disable iff (!aresetn || !clear_n)
      step && ctrl_q.mode == USR_HOLD |=> $stable(stage_q);
   endproperty
   a_hold: assert property (p_hold) else $error("stages changed in hold");

   // While clear is low the stages read zero at every edge.
   property p_clear;
      @(posedge aclk) disable iff (!aresetn)
      !clear_n |-> stage_q == USR_STAGE_RST;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not zero stages");

   // The end outputs always mirror the end stages.
   property p_outs;
      @(posedge aclk) disable iff (!aresetn)
      first_stage_output == parallel_output[0] && last_stage_output == parallel_output[3];
   endproperty
   a_outs: assert property (p_outs) else $error("end outputs disagree");

   // Stages stay put for two idle cycles in a row, whatever the inputs.
   property p_idle;
      @(posedge aclk) disable iff (!aresetn || !clear_n)
      !step ##1 !step |=> stage_q == $past(stage_q, 2);
   endproperty
   a_idle: assert property (p_idle) else $error("stages drifted while idle");

   // A step write produces one step pulse right after the write is taken.
   property p_step_write;
      @(posedge aclk) disable iff (!aresetn)
      wr_fire && awaddr_q == USR_ADDR_STEP |=> step_q ##1 !step_q;
   endproperty
   a_step_write: assert property (p_step_write) else $error("step pulse wrong");

endmodule

`default_nettype wire

// ==== design/usr_pkg.sv ====
// Shared constants and types for the four-stage universal shift register.
`default_nettype none
package usr_pkg;

   // Number of stages in the register.
   localparam int USR_WIDTH = 4;

   // Byte addresses of the software registers on the AXI4-Lite slave.
   localparam logic [4:0] USR_ADDR_CTRL = 5'h00;
   localparam logic [4:0] USR_ADDR_DATA = 5'h04;
   localparam logic [4:0] USR_ADDR_STEP = 5'h08;
   localparam logic [4:0] USR_ADDR_STATUS = 5'h0c;
   localparam logic [4:0] USR_ADDR_DIV = 5'h10;

   // Field positions inside the control word.
   localparam int USR_CTRL_MODE_LSB = 0;
   localparam int USR_CTRL_SRIGHT_BIT = 2;
   localparam int USR_CTRL_SLEFT_BIT = 3;
   localparam int USR_CTRL_RUN_BIT = 4;
   localparam int USR_CTRL_BITS = 5;

   // Values after reset.
   localparam logic [4:0] USR_CTRL_RST = 5'h00;
   localparam logic [3:0] USR_STAGE_RST = 4'h0;
   localparam logic [3:0] USR_DATA_RST = 4'h0;
   localparam logic [15:0] USR_DIV_RST = 16'h0063;

   // AXI response codes.
   localparam logic [1:0] USR_RESP_OKAY = 2'h0;
   localparam logic [1:0] USR_RESP_SLVERR = 2'h2;

   // Mode, coded as {mode_select_high, mode_select_low}; Gray order along hold, right, load, left.
   typedef enum logic [1:0] {
      USR_HOLD = 2'h0,
      USR_SHR = 2'h1,
      USR_LOAD = 2'h3,
      USR_SHL = 2'h2
   } usr_mode_t;

   // Control word as software writes it.
   typedef struct packed {
      logic run;
      logic serial_left_in;
      logic serial_right_in;
      usr_mode_t mode;
   } usr_ctrl_t;

endpackage

`default_nettype wire

// ==== design/usr_rate_div.sv ====
`timescale 1ns/1ps
`default_nettype none

// Free-running divider that makes a one-cycle step pulse while running.
module usr_rate_div import usr_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic [15:0] div_count,
   output logic tick_q
);

   // Cycles since the last tick.
   logic [15:0] cnt_q;

   // Counting restarts while stopped, so the first tick comes a full period after run.
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (cnt_q >= div_count) begin
         cnt_q <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ==== design/usr_stage_core.sv ====
`timescale 1ns/1ps
`default_nettype none

// The four stages and their next-value steering; bit 0 is the first stage.
module usr_stage_core import usr_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear_n,
   input wire logic step,
   input wire usr_ctrl_t ctrl,
   input wire logic [USR_WIDTH-1:0] par_in,
   output logic [USR_WIDTH-1:0] stage_q
);

   // Next value of each stage.
   logic [USR_WIDTH-1:0] stage_d;

   // Each stage picks its own source; the serial inputs only reach the end stages.
   for (genvar i = 0; i < USR_WIDTH; i++) begin : g_stage
      always_comb begin
         unique case (ctrl.mode)
            USR_LOAD: stage_d[i] = par_in[i];
            USR_SHR: begin
               // Right shift moves data from the first stage toward the last.
               if (i == 0) begin
                  stage_d[i] = ctrl.serial_right_in;
               end else begin
                  stage_d[i] = stage_q[(i == 0) ? 0 : i - 1];
               end
            end
            USR_SHL: begin
               // Left shift moves data from the last stage toward the first.
               if (i == USR_WIDTH - 1) begin
                  stage_d[i] = ctrl.serial_left_in;
               end else begin
                  stage_d[i] = stage_q[(i == USR_WIDTH - 1) ? i : i + 1];
               end
            end
            USR_HOLD: stage_d[i] = stage_q[i];
         endcase
      end
   end

   // Clear acts without the clock and beats everything; apart from reset at the clock edge, stages change only on a step.
   always_ff @(posedge aclk or negedge clear_n) begin
      if (!clear_n) begin
         stage_q <= USR_STAGE_RST;
      end else if (!aresetn) begin
         stage_q <= USR_STAGE_RST;
      end else if (step) begin
         stage_q <= stage_d;
      end
   end

endmodule

`default_nettype wire

// ==== test/usr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Far-side system logic: an AXI4-Lite master plus the clear pin driver.
// Released address and data lines carry the inverse of the last value, so a
// slave that samples them late sees wrong bits instead of stale good ones.
module usr_host_model import usr_pkg::*; (
   input wire logic aclk,
   output logic clear_n,
   output logic [4:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [4:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // Idle values at time zero; clear rests high for normal operation.
   initial begin
      clear_n = 1'b1;
      s_axi_awaddr = 5'h1f;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 5'h1f;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
   end

   // Clear is a level, pulsed low to zero the stages; call just after an edge.
   task automatic set_clear(input logic v);
      clear_n <= v;
   endtask

   // Byte-lane strobes for the writes that follow; call just after an edge.
   task automatic set_strobe(input logic [3:0] s);
      s_axi_wstrb <= s;
   endtask

   // One write; each channel is dropped at the edge that takes it.
   task automatic wr(input logic [4:0] a, input logic [31:0] v,
                     output logic [1:0] r, output bit ok);
      ok = 1'b0;
      r = 2'h3;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~v;
         end
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            ok = 1'b1;
            break;
         end
      end
   endtask

   // One read; rready stays up until the answer is sampled.
   task automatic rd(input logic [4:0] a, output logic [31:0] v,
                     output logic [1:0] r, output bit ok);
      ok = 1'b0;
      r = 2'h3;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid) begin
            v = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            ok = 1'b1;
            break;
         end
      end
   endtask
endmodule

`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

// Reset values first, then mode table, clear, back-to-back steps, divider and refusals.
module tb import usr_pkg::*; ();
   logic aclk, aresetn, clear_n;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb, parallel_output, prev;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, first_stage_output, last_stage_output;
   int fail_count, n_compared;

   // One step: control word, parallel inputs, stages expected after it.
   typedef struct packed {
      logic [4:0] ctrl;
      logic [3:0] data;
      logic [3:0] exp;
   } usr_row_t;
   // Load, load with serial inputs set, right and left shifts, then hold.
   usr_row_t rows [7] = '{'{5'h03, 4'ha, 4'ha}, '{5'h0f, 4'h5, 4'h5},
      '{5'h05, 4'h0, 4'hb}, '{5'h01, 4'h0, 4'h6}, '{5'h0a, 4'h0, 4'hb},
      '{5'h02, 4'h0, 4'h5}, '{5'h0c, 4'hf, 4'h5}};

   usr_shift_top i_dut (
      .aclk, .aresetn, .clear_n,
      .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .parallel_output, .first_stage_output, .last_stage_output
   );

   usr_host_model i_host (
      .aclk, .clear_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );

   // A 200 MHz clock.
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("compared %0d, mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Stage outputs, including the two end-stage pins, against one value.
   task automatic chk_st(input logic [3:0] e);
      n_compared++;
      if ({parallel_output, first_stage_output, last_stage_output} !== {e, e[0], e[3]}) begin
         fail_count++;
         $display("[FAIL] %0t stages %h, expected %h", $time, parallel_output, e);
      end
   endtask

   // Read data word.
   task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t word %h, expected %h", $time, g, e);
      end
   endtask

   // Bus response code.
   task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t response %h, expected %h", $time, g, e);
      end
   endtask

   // A transfer that never answered counts once and ends the run.
   task automatic hung(input bit ok);
      if (!ok) begin
         fail_count++;
         $display("[FAIL] %0t bus transfer timed out", $time);
         stop_test();
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] e);
      logic [1:0] r;
      bit ok;
      i_host.wr(a, v, r, ok);
      hung(ok);
      chk_r(r, e);
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] v, input logic [1:0] e);
      logic [1:0] r;
      bit ok;
      i_host.rd(a, v, r, ok);
      hung(ok);
      chk_r(r, e);
   endtask

   initial begin
      aresetn = 1'b0;
      fail_count = 0;
      n_compared = 0;
      prev = 4'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk_st(4'h0);
      rd(USR_ADDR_DIV, d, USR_RESP_OKAY);
      chk_w(d, {16'h0, USR_DIV_RST});
      rd(USR_ADDR_CTRL, d, USR_RESP_OKAY);
      chk_w(d, 32'h0);
      $display("reset test done");
      // Stages must not move on register writes, only on the step.
      foreach (rows[i]) begin
         wr(USR_ADDR_DATA, {28'h0, rows[i].data}, USR_RESP_OKAY);
         wr(USR_ADDR_CTRL, {27'h0, rows[i].ctrl}, USR_RESP_OKAY);
         @(negedge aclk);
         chk_st(prev);
         wr(USR_ADDR_STEP, 32'h1, USR_RESP_OKAY);
         @(negedge aclk);
         chk_st(rows[i].exp);
         rd(USR_ADDR_STATUS, d, USR_RESP_OKAY);
         chk_w(d, {28'h0, rows[i].exp});
         prev = rows[i].exp;
      end
      $display("mode table done");
      // Clear zeroes at once, without an edge, and beats a pending load.
      wr(USR_ADDR_CTRL, 32'h3, USR_RESP_OKAY);
      i_host.set_clear(1'b0);
      #1;
      chk_st(4'h0);
      wr(USR_ADDR_STEP, 32'h1, USR_RESP_OKAY);
      @(negedge aclk);
      chk_st(4'h0);
      @(posedge aclk);
      i_host.set_clear(1'b1);
      wr(USR_ADDR_STEP, 32'h1, USR_RESP_OKAY);
      @(negedge aclk);
      chk_st(4'hf);
      $display("clear test done");
      // Two steps back to back, shifting zeros in from the left.
      wr(USR_ADDR_CTRL, 32'h2, USR_RESP_OKAY);
      wr(USR_ADDR_STEP, 32'h1, USR_RESP_OKAY);
      wr(USR_ADDR_STEP, 32'h1, USR_RESP_OKAY);
      @(negedge aclk);
      chk_st(4'h3);
      $display("back-to-back test done");
      // Divider stepping: right shift of ones, eleven ticks, then stopped.
      wr(USR_ADDR_DIV, 32'h2, USR_RESP_OKAY);
      wr(USR_ADDR_CTRL, 32'h15, USR_RESP_OKAY);
      repeat (30) @(posedge aclk);
      wr(USR_ADDR_CTRL, 32'h0, USR_RESP_OKAY);
      repeat (10) @(posedge aclk);
      @(negedge aclk);
      chk_st(4'hf);
      rd(USR_ADDR_DIV, d, USR_RESP_OKAY);
      chk_w(d, 32'h2);
      $display("divider test done");
      // Unmapped and read-only places are refused and change nothing.
      wr(5'h14, 32'h1, USR_RESP_SLVERR);
      rd(5'h14, d, USR_RESP_SLVERR);
      chk_w(d, 32'h0);
      wr(USR_ADDR_STATUS, 32'h0, USR_RESP_SLVERR);
      rd(USR_ADDR_STATUS, d, USR_RESP_OKAY);
      chk_w(d, 32'hf);
      rd(USR_ADDR_STEP, d, USR_RESP_OKAY);
      chk_w(d, 32'h0);
      // Only the upper divider byte is strobed, so the lower byte keeps its value.
      i_host.set_strobe(4'h2);
      wr(USR_ADDR_DIV, 32'h0505, USR_RESP_OKAY);
      i_host.set_strobe(4'hf);
      rd(USR_ADDR_DIV, d, USR_RESP_OKAY);
      chk_w(d, 32'h0502);
      $display("refusal test done");
      stop_test();
   end
endmodule

`default_nettype wire
